// ===== rtl/mcb_pkg.sv
// Constants for the monitor configuration and status bank
package mcb_pkg;
  // Register offsets
  localparam logic [7:0] PWM1_CEIL_ADDR = 8'h38;
  localparam logic [7:0] PWM2_CEIL_ADDR = 8'h39;
  localparam logic [7:0] PWM3_CEIL_ADDR = 8'h3a;
  localparam logic [7:0] MAIN_CFG_ADDR = 8'h40;
  localparam logic [7:0] FIRST_ALARM_ADDR = 8'h41;
  localparam logic [7:0] SECOND_ALARM_ADDR = 8'h42;
  // Reset values
  localparam logic [7:0] CEIL_RESET = 8'hff;
  localparam logic [7:0] DEFAULT_CEIL = 8'hff;
  localparam logic [7:0] MAIN_CFG_RESET = 8'h01;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Main configuration bit positions
  localparam int CFG_RUN = 0;
  localparam int CFG_LOCK = 1;
  localparam int CFG_READY = 2;
  localparam int CFG_MAX = 3;
  localparam int CFG_PWR = 4;
  localparam int CFG_SPIN = 5;
  localparam int CFG_TMO = 6;
  localparam int CFG_SCALE = 7;
  // First alarm bit positions
  localparam int ALM_SUMMARY = 7;
  // Cycles from reset release until the ready counter completes; the ready bit rises one cycle later
  localparam int READY_DELAY_CYCLES = 16;
  localparam int READY_CNT_W = 5;
endpackage : mcb_pkg

// ===== rtl/mcb_sticky_flags.sv
// Bank of sticky alarm flags, cleared on read once the cause is gone
module mcb_sticky_flags #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Live conditions and read strobe
  input wire logic [WIDTH-1:0] cond,
  input wire logic read_clear,
  // Latched flags
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] next_flags;

  // Set wins over the clear; a read clears only bits whose cause is gone
  always_comb begin
    next_flags = cond | (flags & ~{WIDTH{read_clear}});
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_flag_set_wins: assert property (cond[0] |=> flags[0])
    else $error("flag lost a set event");
  a_flag_read_clear: assert property (read_clear && !cond[0] |=> !flags[0])
    else $error("flag not cleared by read with cause gone");
  a_flag_holds: assert property (flags[0] && !read_clear |=> flags[0])
    else $error("flag dropped without a read");
endmodule : mcb_sticky_flags

// ===== rtl/mcb_ceiling_reg.sv
// One lockable duty-ceiling register
module mcb_ceiling_reg #(
  parameter logic [7:0] RESET_VALUE = 8'hff
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic locked,
  input wire logic [7:0] wr_data,
  // Stored value
  output logic [7:0] value
);
  logic [7:0] next_value;

  always_comb begin
    next_value = value;
    if (wr_en && !locked) begin
      next_value = wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end
endmodule : mcb_ceiling_reg

// ===== rtl/mcb_bank.sv
// Configuration, duty-ceiling and alarm register bank of the monitor
// Functional notes
// - Three 8-bit duty ceilings, one per PWM channel, reset to full scale.
// - With lock set, lockable registers ignore all writes.
// - Main configuration resets to 0x01: monitoring enabled, rest cleared.
// - Run bit 1 uses programmed limits; 0 uses built-in defaults.
// - Clearing run bit keeps programmed limits for later reuse.
// - Once locked, the run bit cannot be changed.
// - Lock bit is write-once and stays set until power cycle.
// - Ready bit is read-only, set by the device when powered up.
// - Full-speed bit drives all fans flat out, resets 0, never locked.
// - Lockable power-display bit is stored for software.
// - Spin-up-detect-off bit holds PWM high for the whole timeout.
// - Lockable bus-timeout bit: 1 enables the serial bus timeout.
// - Lockable supply-scale bit: 1 measures a 5 V rail, 0 a 3.3 V rail.
// - First alarm register resets to zero and is read-only.
// - Bit 0 latches 2.5 V violations; read clears it once gone.
// - Bits 1 and 2 latch core and main supply violations likewise.
// - Bit 3 flags 5 V, or the overtemp timer limit when so configured.
// - Bits 4 to 6 latch remote-1, local, remote-2 temperature violations.
// - Bit 7 reads as the OR of the second alarm register.
// - Second alarm register at 0x42, reset zero, feeds the summary bit.
module mcb_bank #(
  parameter int CHANNELS = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port from the serial bus engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // Live limit conditions from the measurement engines
  input wire logic [6:0] first_cond,
  input wire logic overtemp_timer_cond,
  input wire logic overtemp_signal_mode,
  input wire logic [7:0] second_cond,
  // Controls to the fan loop and measurement engines
  output logic [7:0] duty_cap [CHANNELS],
  output logic monitor_run,
  output logic config_locked,
  output logic device_ready,
  output logic all_fans_max,
  output logic power_display_flag,
  output logic spinup_detect_off,
  output logic bus_timeout_ctrl,
  output logic supply_scale_5v
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  logic [7:0] main_cfg;
  logic [7:0] next_main_cfg;
  logic [7:0] ceiling [CHANNELS];
  logic [7:0] first_flags;
  logic [7:0] second_flags;
  logic [7:0] first_view;
  logic [7:0] next_rd_data;
  logic [7:0] next_duty_cap [CHANNELS];
  logic [7:0] alarm_set;
  logic [mcb_pkg::READY_CNT_W-1:0] ready_cnt;
  logic [mcb_pkg::READY_CNT_W-1:0] next_ready_cnt;
  logic ready_done;
  logic cfg_wr;
  logic first_rd;
  logic second_rd;

  assign cfg_wr = reg_wr_en && hit(reg_addr, mcb_pkg::MAIN_CFG_ADDR);
  assign first_rd = reg_rd_en && hit(reg_addr, mcb_pkg::FIRST_ALARM_ADDR);
  assign second_rd = reg_rd_en && hit(reg_addr, mcb_pkg::SECOND_ALARM_ADDR);
  assign ready_done = (ready_cnt == mcb_pkg::READY_CNT_W'(mcb_pkg::READY_DELAY_CYCLES));

  // Duty ceilings, held regardless of the run bit
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ceil
      mcb_ceiling_reg #(
        .RESET_VALUE(mcb_pkg::CEIL_RESET)
      ) u_ceil (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && hit(reg_addr, mcb_pkg::PWM1_CEIL_ADDR + 8'(g))),
        .locked(main_cfg[mcb_pkg::CFG_LOCK]),
        .wr_data(reg_wr_data),
        .value(ceiling[g])
      );
    end
  endgenerate

  // Power-up delay before ready
  always_comb begin
    next_ready_cnt = ready_cnt;
    if (!ready_done) begin
      next_ready_cnt = ready_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_cnt <= '0;
    end else begin
      ready_cnt <= next_ready_cnt;
    end
  end

  // Main configuration
  always_comb begin
    next_main_cfg = main_cfg;
    next_main_cfg[mcb_pkg::CFG_READY] = ready_done;
    if (cfg_wr) begin
      next_main_cfg[mcb_pkg::CFG_MAX] = reg_wr_data[mcb_pkg::CFG_MAX];
      next_main_cfg[mcb_pkg::CFG_SPIN] = reg_wr_data[mcb_pkg::CFG_SPIN];
      if (!main_cfg[mcb_pkg::CFG_LOCK]) begin
        next_main_cfg[mcb_pkg::CFG_RUN] = reg_wr_data[mcb_pkg::CFG_RUN];
        next_main_cfg[mcb_pkg::CFG_PWR] = reg_wr_data[mcb_pkg::CFG_PWR];
        next_main_cfg[mcb_pkg::CFG_TMO] = reg_wr_data[mcb_pkg::CFG_TMO];
        next_main_cfg[mcb_pkg::CFG_SCALE] = reg_wr_data[mcb_pkg::CFG_SCALE];
        next_main_cfg[mcb_pkg::CFG_LOCK] = reg_wr_data[mcb_pkg::CFG_LOCK];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_cfg <= mcb_pkg::MAIN_CFG_RESET;
    end else begin
      main_cfg <= next_main_cfg;
    end
  end

  // Alarm flag banks
  always_comb begin
    alarm_set = {1'b0, first_cond};
    if (overtemp_signal_mode) begin
      alarm_set[3] = overtemp_timer_cond;
    end
  end

  mcb_sticky_flags #(
    .WIDTH(8)
  ) u_first (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cond(alarm_set),
    .read_clear(first_rd),
    .flags(first_flags)
  );

  mcb_sticky_flags #(
    .WIDTH(8)
  ) u_second (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cond(second_cond),
    .read_clear(second_rd),
    .flags(second_flags)
  );

  always_comb begin
    first_view = first_flags;
    first_view[mcb_pkg::ALM_SUMMARY] = |second_flags;
  end

  // Read mux; writes to read-only offsets fall through untouched
  always_comb begin
    next_rd_data = mcb_pkg::UNMAPPED_READ;
    for (int i = 0; i < CHANNELS; i++) begin
      if (hit(reg_addr, mcb_pkg::PWM1_CEIL_ADDR + 8'(i))) begin
        next_rd_data = ceiling[i];
      end
    end
    if (hit(reg_addr, mcb_pkg::MAIN_CFG_ADDR)) begin
      next_rd_data = main_cfg;
    end
    if (hit(reg_addr, mcb_pkg::FIRST_ALARM_ADDR)) begin
      next_rd_data = first_view;
    end
    if (hit(reg_addr, mcb_pkg::SECOND_ALARM_ADDR)) begin
      next_rd_data = second_flags;
    end
    if (!reg_rd_en) begin
      next_rd_data = reg_rd_data;
    end
  end

  // Effective ceilings seen by the fan loop
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      next_duty_cap[i] = main_cfg[mcb_pkg::CFG_RUN] ? ceiling[i] : mcb_pkg::DEFAULT_CEIL;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= '0;
      reg_rd_valid <= 1'b0;
      monitor_run <= 1'b0;
      config_locked <= 1'b0;
      device_ready <= 1'b0;
      all_fans_max <= 1'b0;
      power_display_flag <= 1'b0;
      spinup_detect_off <= 1'b0;
      bus_timeout_ctrl <= 1'b0;
      supply_scale_5v <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        duty_cap[i] <= mcb_pkg::DEFAULT_CEIL;
      end
    end else begin
      reg_rd_data <= next_rd_data;
      reg_rd_valid <= reg_rd_en;
      monitor_run <= main_cfg[mcb_pkg::CFG_RUN];
      config_locked <= main_cfg[mcb_pkg::CFG_LOCK];
      device_ready <= main_cfg[mcb_pkg::CFG_READY];
      all_fans_max <= main_cfg[mcb_pkg::CFG_MAX];
      power_display_flag <= main_cfg[mcb_pkg::CFG_PWR];
      spinup_detect_off <= main_cfg[mcb_pkg::CFG_SPIN];
      bus_timeout_ctrl <= main_cfg[mcb_pkg::CFG_TMO];
      supply_scale_5v <= main_cfg[mcb_pkg::CFG_SCALE];
      for (int i = 0; i < CHANNELS; i++) begin
        duty_cap[i] <= next_duty_cap[i];
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_locked_cfg_write;
    main_cfg[mcb_pkg::CFG_LOCK] && cfg_wr;
  endsequence

  sequence s_open_cfg_write;
    !main_cfg[mcb_pkg::CFG_LOCK] && cfg_wr;
  endsequence

  sequence s_open_ceil_write;
    !main_cfg[mcb_pkg::CFG_LOCK] && reg_wr_en && hit(reg_addr, mcb_pkg::PWM2_CEIL_ADDR);
  endsequence

  a_lock_stays_set: assert property (
    main_cfg[mcb_pkg::CFG_LOCK] |=> main_cfg[mcb_pkg::CFG_LOCK])
    else $error("lock bit cleared");
  a_lock_takes: assert property (
    cfg_wr && reg_wr_data[mcb_pkg::CFG_LOCK] |=> main_cfg[mcb_pkg::CFG_LOCK])
    else $error("lock bit write lost");
  a_run_frozen: assert property (
    s_locked_cfg_write |=> $stable(main_cfg[mcb_pkg::CFG_RUN]))
    else $error("run bit changed after lock");
  a_run_written: assert property (
    s_open_cfg_write |=> main_cfg[mcb_pkg::CFG_RUN] == $past(reg_wr_data[mcb_pkg::CFG_RUN]))
    else $error("run bit write lost while unlocked");
  a_locked_cfg_bits: assert property (
    s_locked_cfg_write |=> $stable({main_cfg[7:6], main_cfg[4]}))
    else $error("lockable config bit changed after lock");
  a_fullspd_unlocked: assert property (
    s_locked_cfg_write |=> main_cfg[mcb_pkg::CFG_MAX] == $past(reg_wr_data[3]))
    else $error("full speed bit blocked by lock");
  a_spin_unlocked: assert property (
    s_locked_cfg_write |=> main_cfg[mcb_pkg::CFG_SPIN] == $past(reg_wr_data[mcb_pkg::CFG_SPIN]))
    else $error("spin-up bit blocked by lock");
  a_ready_readonly: assert property (
    cfg_wr |=> main_cfg[mcb_pkg::CFG_READY] == $past(ready_done))
    else $error("ready bit taken from a write");
  a_ceil_locked: assert property (
    main_cfg[mcb_pkg::CFG_LOCK] |=> $stable(ceiling[0]))
    else $error("ceiling changed while locked");
  a_ceil_written: assert property (
    s_open_ceil_write |=> ceiling[1] == $past(reg_wr_data))
    else $error("ceiling write lost while unlocked");
  a_ceil_kept: assert property (
    !main_cfg[mcb_pkg::CFG_RUN] && !reg_wr_en |=> $stable(ceiling[2]))
    else $error("ceiling changed while stopped");
  a_default_cap: assert property (
    !main_cfg[mcb_pkg::CFG_RUN] |=> duty_cap[0] == mcb_pkg::DEFAULT_CEIL)
    else $error("default ceiling not used while stopped");
  a_prog_cap: assert property (
    main_cfg[mcb_pkg::CFG_RUN] |=> duty_cap[1] == $past(ceiling[1]))
    else $error("programmed ceiling not used while running");
  a_cfg_outputs: assert property (
    1'b1 |=> {supply_scale_5v, bus_timeout_ctrl, spinup_detect_off, power_display_flag,
      all_fans_max, device_ready, config_locked, monitor_run} == $past(main_cfg))
    else $error("control outputs differ from configuration");
  a_first_set_wins: assert property (
    1'b1 |=> (first_flags & $past(alarm_set)) == $past(alarm_set))
    else $error("first alarm flag missed its cause");
  a_first_rd_clear: assert property (
    first_rd |=> (first_flags & ~$past(alarm_set)) == 8'h00)
    else $error("first alarm flag survived a read with cause gone");
  a_overtemp_mode: assert property (
    overtemp_signal_mode && !overtemp_timer_cond && !first_flags[3] |=> !first_flags[3])
    else $error("bit 3 set from the 5 V cause in timer mode");
  a_second_set_wins: assert property (
    1'b1 |=> (second_flags & $past(second_cond)) == $past(second_cond))
    else $error("second alarm flag missed its cause");
  a_summary_or: assert property (
    first_rd |=> reg_rd_valid && reg_rd_data[7] == $past(|second_flags))
    else $error("summary bit differs from second bank");
  a_ready_timing: assert property (
    $rose(main_cfg[mcb_pkg::CFG_READY]) |=> main_cfg[mcb_pkg::CFG_READY][*4])
    else $error("ready bit dropped");
endmodule : mcb_bank

// ===== tb/mcb_host_model.sv
// Host model that drives the register port of the bank
module mcb_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_addr, reg_wr_en, reg_wr_data, reg_rd_en} = '0;
  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_wr_data = data;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    {reg_addr, reg_wr_data} = ~{reg_addr, reg_wr_data};
  endtask : wr
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clk_sys);
    reg_addr = addr;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    {reg_addr, reg_wr_data} = ~{reg_addr, reg_wr_data};
    for (int n = 0; n < 4 && reg_rd_valid !== 1'b1; n++) begin
      @(negedge clk_sys);
    end
    ok = (reg_rd_valid === 1'b1);
    data = reg_rd_data;
  endtask : rd
endmodule : mcb_host_model

// ===== tb/monitor_config_status_bank_test.sv
// Self-checking bench for the configuration, ceiling and alarm bank
module monitor_config_status_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, second_cond;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, overtemp_timer_cond, overtemp_signal_mode;
  wire [7:0] ctl;
  logic [6:0] first_cond;
  logic [7:0] duty_cap [3];
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  mcb_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid));
  mcb_bank u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .first_cond(first_cond),
    .overtemp_timer_cond(overtemp_timer_cond), .overtemp_signal_mode(overtemp_signal_mode),
    .second_cond(second_cond), .duty_cap(duty_cap), .monitor_run(ctl[0]), .config_locked(ctl[1]),
    .device_ready(ctl[2]), .all_fans_max(ctl[3]), .power_display_flag(ctl[4]),
    .spinup_detect_off(ctl[5]), .bus_timeout_ctrl(ctl[6]), .supply_scale_5v(ctl[7]));
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(addr, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rd_chk
  task automatic caps_chk(input logic [7:0] base, input logic prog);
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      chk(duty_cap[i], prog ? base ^ 8'(i) : 8'hff);
    end
  endtask : caps_chk
  task automatic t_reset();
    chk(duty_cap[0], 8'hff);
    rd_chk(8'h40, 8'h01);
    repeat (20) @(negedge clk_sys);
    rd_chk(8'h40, 8'h05);
    chk(ctl, 8'h05);
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'h38 + 8'(i), 8'hff);
    end
    rd_chk(8'h41, 8'h00);
    rd_chk(8'h50, 8'h00);
  endtask : t_reset
  task automatic t_run();
    for (int i = 0; i < 3; i++) begin
      u_host.wr(8'h38 + 8'(i), 8'h5a ^ 8'(i));
    end
    caps_chk(8'h5a, 1'b1);
    u_host.wr(8'h40, 8'h00);
    caps_chk(8'h5a, 1'b0);
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'h38 + 8'(i), 8'h5a ^ 8'(i));
    end
    u_host.wr(8'h40, 8'h01);
    caps_chk(8'h5a, 1'b1);
    u_host.wr(8'h40, 8'hf9);
    rd_chk(8'h40, 8'hfd);
    chk(ctl, 8'hfd);
    u_host.wr(8'h40, 8'h01);
    rd_chk(8'h40, 8'h05);
  endtask : t_run
  task automatic t_alarms();
    for (int i = 0; i < 7; i++) begin
      first_cond = 7'h01 << i;
      repeat (2) @(negedge clk_sys);
      rd_chk(8'h41, 8'h01 << i);
      rd_chk(8'h41, 8'h01 << i);
      first_cond = 7'h00;
      rd_chk(8'h41, 8'h01 << i);
      rd_chk(8'h41, 8'h00);
    end
    {overtemp_signal_mode, first_cond} = {1'b1, 7'h08};
    overtemp_timer_cond = 1'b1;
    repeat (2) @(negedge clk_sys);
    rd_chk(8'h41, 8'h08);
    overtemp_timer_cond = 1'b0;
    rd_chk(8'h41, 8'h08);
    rd_chk(8'h41, 8'h00);
    {overtemp_signal_mode, first_cond} = 8'h00;
    second_cond = 8'h20;
    repeat (2) @(negedge clk_sys);
    rd_chk(8'h41, 8'h80);
    rd_chk(8'h42, 8'h20);
    second_cond = 8'h00;
    rd_chk(8'h42, 8'h20);
    rd_chk(8'h42, 8'h00);
    rd_chk(8'h41, 8'h00);
  endtask : t_alarms
  task automatic t_lock();
    u_host.wr(8'h40, 8'h03);
    rd_chk(8'h40, 8'h07);
    u_host.wr(8'h38, 8'haa);
    rd_chk(8'h38, 8'h5a);
    u_host.wr(8'h40, 8'hf8);
    rd_chk(8'h40, 8'h2f);
    chk(ctl, 8'h2f);
    u_host.wr(8'h41, 8'hff);
    rd_chk(8'h41, 8'h00);
    caps_chk(8'h5a, 1'b1);
  endtask : t_lock
  task automatic t_rereset();
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
  endtask : t_rereset
  initial begin
    {first_cond, second_cond, overtemp_timer_cond, overtemp_signal_mode} = '0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_run();
    t_alarms();
    t_lock();
    t_rereset();
    wrap_up();
  end
endmodule : monitor_config_status_bank_test
